// ---- rfcl_latch.sv ----
// RF front end control latch with timed attenuator driver boost
`timescale 1ns/1ps
// Behaviour
// - line one engages the 10 dB attenuator section, else bypasses it
// - line seven engages the 20 dB attenuator section, else bypasses it
// - line three engages the 30 dB attenuator section, else bypasses it
// - line four enables the current drivers boosting attenuator driver supply
// - line five enables transfer switch driver, external mixer path
// - line six high selects 829 MHz IF, low selects 2072 MHz
// - line eight enables baseline clipping
// - attenuation 0 to 60 dB in 10 dB steps from three sections
// - each attenuator section has its own relay drive from the latch
// - exactly one second converter path active, per band
// - lines captured only on an access to address 4F
// - negative pulse raises attenuator driver supply for about 100 ms
module rfcl_latch
  import rfcl_pkg::*;
#(
  parameter logic [22:0] BOOST_CYCLES = RFCL_BOOST_CYCLES
) (
  // Clock, enable and reset
  input  wire logic       MCLK_IN,
  input  wire logic       CLK_EN_IN,
  input  wire logic       RESETN_IN,
  // Microcomputer bus
  input  wire logic [7:0] ADDR_IN,
  input  wire logic [7:0] DATA_IN,
  input  wire logic       WR_STROBE_IN,
  input  wire logic       BOOST_PULSE_N_IN,
  // Relay and driver lines
  output logic            ATTEN_10DB_LINE_OUT,
  output logic            ATTEN_20DB_LINE_OUT,
  output logic            ATTEN_30DB_LINE_OUT,
  output logic            DRIVER_BOOST_LINE_OUT,
  output logic            EXT_PATH_SWITCH_LINE_OUT,
  output logic            IF_CHOICE_LINE_OUT,
  output logic            IF_2072_SELECT_OUT,
  output logic            BASELINE_CLIP_LINE_OUT,
  output logic            UNUSED_LINE_OUT,
  output logic            BOOST_SUPPLY_OUT,
  output logic [5:0]      ATTEN_TOTAL_DB_OUT
);

  typedef struct packed {
    logic [7:0]  lines;
    logic [22:0] boost_cnt;
    logic        boost_on;
    logic        pulse_n_prev;
    logic        if_2072;
    logic [5:0]  atten_db;
  } rfcl_state_type;

  rfcl_state_type st_q;
  rfcl_state_type st_d;

  // Qualified events of the current cycle
  logic        latch_write;
  logic        pulse_fell;
  logic        boost_expired;
  logic [7:0]  lines_next;
  logic [22:0] boost_load;

  // True when the bus addresses the control latch
  function automatic logic rfcl_is_latch_write(
    input logic       strobe,
    input logic [7:0] addr
  );
    logic hit;
    hit = 1'b0;
    if (strobe) begin
      if (addr == RFCL_LATCH_ADDR) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // High then low on two enabled samples
  function automatic logic rfcl_pulse_fell(
    input logic prev_n,
    input logic now_n
  );
    logic fell;
    fell = 1'b0;
    if (prev_n && !now_n) begin
      fell = 1'b1;
    end
    return fell;
  endfunction

  // One attenuator section's share in dB
  function automatic logic [5:0] rfcl_atten_section(
    input logic       engaged,
    input logic [5:0] weight
  );
    logic [5:0] share;
    share = 6'h00;
    if (engaged) begin
      share = weight;
    end
    return share;
  endfunction

  // Attenuation in dB from the three section bits
  function automatic logic [5:0] rfcl_atten_db(
    input logic [7:0] l
  );
    logic [5:0] sum;
    sum = 6'h00;
    sum = sum + rfcl_atten_section(l[RFCL_BIT_ATT10], 6'h0a);
    sum = sum + rfcl_atten_section(l[RFCL_BIT_ATT20], 6'h14);
    sum = sum + rfcl_atten_section(l[RFCL_BIT_ATT30], 6'h1e);
    return sum;
  endfunction

  // The 2072 MHz path runs whenever 829 MHz is not chosen
  function automatic logic rfcl_if_2072(
    input logic [7:0] l
  );
    logic sel;
    sel = ~l[RFCL_BIT_IFCHOICE];
    return sel;
  endfunction

  // Boost counter step, held at zero once run out
  function automatic logic [22:0] rfcl_count_down(
    input logic [22:0] cnt
  );
    logic [22:0] nxt;
    nxt = cnt;
    if (cnt != RFCL_BOOST_RESET) begin
      nxt = cnt - 23'h000001;
    end
    return nxt;
  endfunction

  // Boost counter has reached its last cycle
  function automatic logic rfcl_expired(
    input logic [22:0] cnt
  );
    logic done;
    done = 1'b0;
    if (cnt == RFCL_BOOST_RESET) begin
      done = 1'b1;
    end
    return done;
  endfunction

  // One latched line by its bit position
  function automatic logic rfcl_line(
    input logic [7:0] l,
    input int         pos
  );
    logic v;
    v = l[pos];
    return v;
  endfunction

  // Decoded write of the whole byte
  assign latch_write   = rfcl_is_latch_write(WR_STROBE_IN, ADDR_IN);

  // Falling edge of the boost request
  assign pulse_fell    = rfcl_pulse_fell(st_q.pulse_n_prev, BOOST_PULSE_N_IN);

  // Last cycle of the boost window
  assign boost_expired = rfcl_expired(st_q.boost_cnt);

  // All eight lines change together or not at all
  assign lines_next    = latch_write ? DATA_IN : st_q.lines;

  // Window length is BOOST_CYCLES high cycles; zero is not a usable setting
  assign boost_load    = BOOST_CYCLES - 23'h000001;

  always_comb begin
    st_d = st_q;
    if (CLK_EN_IN) begin
      // Edge history follows every enabled sample
      st_d.pulse_n_prev = BOOST_PULSE_N_IN;

      // Whole byte replaced on a decoded write
      st_d.lines = lines_next;

      // Derived views track the new byte in the same cycle
      st_d.atten_db = rfcl_atten_db(lines_next);
      st_d.if_2072  = rfcl_if_2072(lines_next);

      // Retrigger wins over expiry
      if (pulse_fell) begin
        st_d.boost_on  = 1'b1;
        st_d.boost_cnt = boost_load;
      end else if (st_q.boost_on) begin
        if (boost_expired) begin
          st_d.boost_on  = 1'b0;
          st_d.boost_cnt = RFCL_BOOST_RESET;
        end else begin
          st_d.boost_cnt = rfcl_count_down(st_q.boost_cnt);
        end
      end else begin
        st_d.boost_on  = 1'b0;
        st_d.boost_cnt = RFCL_BOOST_RESET;
      end
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      st_q.lines        <= RFCL_LATCH_RESET;
      st_q.boost_cnt    <= RFCL_BOOST_RESET;
      st_q.boost_on     <= 1'b0;
      st_q.pulse_n_prev <= 1'b1;
      st_q.if_2072      <= 1'b1;
      st_q.atten_db     <= 6'h00;
    end else begin
      st_q <= st_d;
    end
  end

  // Each section drives its own relay
  assign ATTEN_10DB_LINE_OUT      = rfcl_line(st_q.lines, RFCL_BIT_ATT10);

  assign ATTEN_20DB_LINE_OUT      = rfcl_line(st_q.lines, RFCL_BIT_ATT20);

  assign ATTEN_30DB_LINE_OUT      = rfcl_line(st_q.lines, RFCL_BIT_ATT30);

  // Driver supply and transfer switch
  assign DRIVER_BOOST_LINE_OUT    = rfcl_line(st_q.lines, RFCL_BIT_BOOST);

  assign EXT_PATH_SWITCH_LINE_OUT = rfcl_line(st_q.lines, RFCL_BIT_EXTPATH);

  // Intermediate frequency choice
  assign IF_CHOICE_LINE_OUT       = rfcl_line(st_q.lines, RFCL_BIT_IFCHOICE);

  assign IF_2072_SELECT_OUT       = st_q.if_2072;

  // Display clipping and the spare line
  assign BASELINE_CLIP_LINE_OUT   = rfcl_line(st_q.lines, RFCL_BIT_CLIP);

  assign UNUSED_LINE_OUT          = rfcl_line(st_q.lines, RFCL_BIT_UNUSED);

  // Timed supply raise for the solenoids
  assign BOOST_SUPPLY_OUT         = st_q.boost_on;

  // Total attenuation view
  assign ATTEN_TOTAL_DB_OUT       = st_q.atten_db;

  // The window below is padding-free logic documentation of timing:
  // a falling request sampled at edge 0 shows the supply high after
  // edges 0 through BOOST_CYCLES-1, and low after edge BOOST_CYCLES.
  // A new falling request inside the window reloads the counter, so
  // the supply stays high for a full window after the last request.
  // A write and a request in one cycle are independent of each other.
  // With the clock enable low nothing moves, including edge history,
  // so a request that falls and rises while frozen is never seen.
  // The latched byte is write only; there is no read path back.
  // Line two is carried through to its pin though it drives nothing.
  // The total and the path select are registered with the lines,
  // so all outputs except BOOST_SUPPLY_OUT change on the same edge after a write.

endmodule

// ---- rfcl_pkg.sv ----
// Package of constants for the RF front end control latch
package rfcl_pkg;
  // Address of the control latch on the microcomputer bus
  localparam logic [7:0]  RFCL_LATCH_ADDR      = 8'h4f;
  localparam logic [7:0]  RFCL_LATCH_RESET     = 8'h00;
  // Bit positions of the control lines
  localparam int          RFCL_BIT_ATT10       = 0;
  localparam int          RFCL_BIT_UNUSED      = 1;
  localparam int          RFCL_BIT_ATT30       = 2;
  localparam int          RFCL_BIT_BOOST       = 3;
  localparam int          RFCL_BIT_EXTPATH     = 4;
  localparam int          RFCL_BIT_IFCHOICE    = 5;
  localparam int          RFCL_BIT_ATT20       = 6;
  localparam int          RFCL_BIT_CLIP        = 7;
  // Boost supply hold time
  localparam int          RFCL_BOOST_MS        = 100;
  localparam int          RFCL_CLK_HZ          = 50000000;
  localparam longint      RFCL_BOOST_CYCLES_L  =
    (64'(RFCL_BOOST_MS) * 64'(RFCL_CLK_HZ)) / 64'd1000;
  localparam logic [22:0] RFCL_BOOST_CYCLES    = 23'(RFCL_BOOST_CYCLES_L);
  localparam logic [22:0] RFCL_BOOST_RESET     = 23'h000000;
endpackage

// ---- rfcl_monitor.sv ----
// Checker for the RF front end control latch
`timescale 1ns/1ps
module rfcl_monitor
  import rfcl_pkg::*;
(
  input wire logic MCLK_IN, CLK_EN_IN, RESETN_IN, WR_STROBE_IN, BOOST_PULSE_N_IN,
  input wire logic [7:0] ADDR_IN, DATA_IN,
  input wire logic ATTEN_10DB_LINE_OUT, ATTEN_20DB_LINE_OUT, ATTEN_30DB_LINE_OUT,
  input wire logic DRIVER_BOOST_LINE_OUT, EXT_PATH_SWITCH_LINE_OUT, IF_CHOICE_LINE_OUT,
  input wire logic IF_2072_SELECT_OUT, BASELINE_CLIP_LINE_OUT, UNUSED_LINE_OUT,
  input wire logic BOOST_SUPPLY_OUT,
  input wire logic [5:0] ATTEN_TOTAL_DB_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RESETN_IN);
  logic       wr;
  logic [7:0] q;
  assign wr = CLK_EN_IN && WR_STROBE_IN && ADDR_IN == RFCL_LATCH_ADDR;
  assign q = {BASELINE_CLIP_LINE_OUT, ATTEN_20DB_LINE_OUT, IF_CHOICE_LINE_OUT,
    EXT_PATH_SWITCH_LINE_OUT, DRIVER_BOOST_LINE_OUT, ATTEN_30DB_LINE_OUT, UNUSED_LINE_OUT,
    ATTEN_10DB_LINE_OUT};
  AST_ATT10: assert property (wr |=> q[0] == $past(DATA_IN[0])) else $error("att10");
  AST_ATT20: assert property (wr |=> q[6] == $past(DATA_IN[6])) else $error("att20");
  AST_ATT30: assert property (wr |=> q[2] == $past(DATA_IN[2])) else $error("att30");
  AST_BOOST: assert property (wr |=> q[3] == $past(DATA_IN[3])) else $error("boost");
  AST_EXT: assert property (wr |=> q[4] == $past(DATA_IN[4])) else $error("ext");
  AST_IF: assert property (wr |=> q[5] == $past(DATA_IN[5])) else $error("if");
  AST_CLIP: assert property (wr |=> q[7] == $past(DATA_IN[7])) else $error("clip");
  AST_ONEPATH: assert property (IF_2072_SELECT_OUT != q[5]) else $error("path");
  AST_TOTAL: assert property (ATTEN_TOTAL_DB_OUT == 6'(10 * q[0] + 20 * q[6] + 30 * q[2]))
    else $error("total");
  AST_HOLD: assert property (!wr |=> $stable(q)) else $error("hold");
  AST_SUPPLY: assert property (CLK_EN_IN && $fell(BOOST_PULSE_N_IN) |=> BOOST_SUPPLY_OUT [*8])
    else $error("supply");
  cover property (wr);
  cover property ($rose(BOOST_SUPPLY_OUT));
  cover property (ATTEN_TOTAL_DB_OUT == 6'd60);
endmodule
bind rfcl_latch rfcl_monitor mon (.*);

// ---- rfcl_host.sv ----
// Microcomputer model writing the control latch
`timescale 1ns/1ps
module rfcl_host (
  input  wire logic clk_in,
  output logic [7:0] addr_out, data_out,
  output logic       strobe_out, pulse_n_out
);
  initial begin addr_out = 8'h00; data_out = 8'h00; strobe_out = 1'b0; pulse_n_out = 1'b1; end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in); #1 addr_out = a; data_out = d; strobe_out = 1'b1;
    @(posedge clk_in); #1 strobe_out = 1'b0; addr_out = ~a; data_out = ~d;
  endtask
  // Bands 2-4 take 829 MHz, else 2072; waveguide or button picks external path
  task automatic band(input int b, input logic button);
    wr(8'h4f, {2'h0, b >= 2 && b <= 4, b > 5 || button, 4'h0});
  endtask
  task automatic pulse();
    @(posedge clk_in); #1 pulse_n_out = 1'b0;
    @(posedge clk_in); #1 pulse_n_out = 1'b1;
  endtask
endmodule

// ---- tb_top.sv ----
// Testbench for the RF front end control latch
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, en = 1, rstn = 0, s, p, l10, l20, l30, lb, le, li, l2, lc, lu, bs;
  logic [7:0] a, d;
  logic [5:0] tot;
  int err_count = 0, total_checks = 0, n = 0;
  wire [7:0] q = {lc, l20, li, le, lb, l30, lu, l10};
  always #10 clk = ~clk;
  rfcl_host host (.clk_in(clk), .addr_out(a), .data_out(d), .strobe_out(s), .pulse_n_out(p));
  rfcl_latch #(.BOOST_CYCLES(23'd8)) uut (.MCLK_IN(clk), .CLK_EN_IN(en), .RESETN_IN(rstn),
    .ADDR_IN(a), .DATA_IN(d), .WR_STROBE_IN(s), .BOOST_PULSE_N_IN(p), .ATTEN_10DB_LINE_OUT(l10),
    .ATTEN_20DB_LINE_OUT(l20), .ATTEN_30DB_LINE_OUT(l30), .DRIVER_BOOST_LINE_OUT(lb),
    .EXT_PATH_SWITCH_LINE_OUT(le), .IF_CHOICE_LINE_OUT(li), .IF_2072_SELECT_OUT(l2),
    .BASELINE_CLIP_LINE_OUT(lc), .UNUSED_LINE_OUT(lu), .BOOST_SUPPLY_OUT(bs),
    .ATTEN_TOTAL_DB_OUT(tot));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin err_count++; $display("Error %0t: got %h want %h", $time, g, e); end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin repeat (3000) @(posedge clk); err_count++; end_sim(); end
  initial begin
    repeat (5) @(posedge clk);
    #1 rstn = 1;
    chk({q[7:1], l2}, 8'h01);
    host.wr(8'h4f, 8'h45);
    chk({2'h0, tot}, 8'h3c);
    chk(q, 8'h45);
    for (int i = 0; i < 8; i++) begin host.wr(8'h4f, 8'h01 << i); chk(q, 8'h01 << i); end
    host.wr(8'h4e, 8'hff);
    chk(q, 8'h80);
    en = 0; host.wr(8'h4f, 8'h0f); en = 1;
    chk(q, 8'h80);
    $display("test latch done");
    for (int b = 1; b <= 7; b++) begin host.band(b, b == 1); chk({li, l2, le}, {b >= 2 && b <= 4, !(b >= 2 && b <= 4), b > 5 || b == 1}); end
    $display("test band done");
    host.pulse();
    n = bs;
    for (int k = 0; k < 30; k++) begin @(posedge clk); #1 n += bs; end
    chk(8'(n), 8'd8);
    $display("test boost done");
    end_sim();
  end
endmodule
